// ---- rtl/prc_pkg.sv ----
/*
 Shared constants for the power-up run/stop and storage-retention controller:
 register offsets, field positions, reset values, policy codes and state codes.
 Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
*/
package prc_pkg;

	// ------------------------------------------------------------------
	// Storage geometry
	// ------------------------------------------------------------------
	localparam int unsigned PRC_IDX_W = 10;
	localparam logic [9:0] PRC_IDX_LAST = 10'h3FF;
	localparam int unsigned PRC_NCLS = 4;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] PRC_OFF_CTRL = 8'h00;
	localparam logic [7:0] PRC_OFF_STATUS = 8'h04;
	localparam logic [7:0] PRC_OFF_INT_STATUS = 8'h08;
	localparam logic [7:0] PRC_OFF_INT_MASK = 8'h0C;
	localparam logic [7:0] PRC_OFF_MODE = 8'h10;
	localparam logic [7:0] PRC_OFF_RANGE_BASE = 8'h20;

	// ------------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------------
	localparam int unsigned PRC_CTRL_GO = 0;
	localparam int unsigned PRC_CTRL_PUP_LSB = 1;
	localparam int unsigned PRC_CTRL_BKP_RUN = 3;
	localparam int unsigned PRC_CTRL_STOP_EN = 4;
	localparam int unsigned PRC_CTRL_RST_EN = 5;
	localparam int unsigned PRC_CTRL_CMD_RUN = 8;
	localparam int unsigned PRC_CTRL_CMD_STOP = 9;
	localparam logic [31:0] PRC_CTRL_WMASK = 32'h0000003F;
	localparam logic [31:0] PRC_CTRL_RST = 32'h00000000;

	// Power-up policy codes.
	localparam logic [1:0] PRC_PUP_KEEP = 2'h0;
	localparam logic [1:0] PRC_PUP_RUN = 2'h1;
	localparam logic [1:0] PRC_PUP_STOP = 2'h2;

	// ------------------------------------------------------------------
	// Storage policy codes, two bits per class in the mode register
	// ------------------------------------------------------------------
	localparam logic [1:0] PRC_MODE_CLEAR_ALL = 2'h0;
	localparam logic [1:0] PRC_MODE_KEEP_ALL = 2'h1;
	localparam logic [1:0] PRC_MODE_RANGE = 2'h2;
	localparam logic [7:0] PRC_MODE_RST = 8'h50;
	// Classes: 0 relays, 1 shift registers, 2 counters, 3 data registers.
	localparam logic [3:0] PRC_RANGE_KEEPS = 4'h3;

	// Range register fields.
	localparam int unsigned PRC_RNG_LO_LSB = 0;
	localparam int unsigned PRC_RNG_HI_LSB = 16;
	localparam logic [31:0] PRC_RNG_WMASK = 32'h03FF03FF;

	// ------------------------------------------------------------------
	// Status and interrupt bits
	// ------------------------------------------------------------------
	localparam int unsigned PRC_ST_FLAG = 0;
	localparam int unsigned PRC_ST_RUN = 1;
	localparam int unsigned PRC_ST_CLEAR = 2;
	localparam int unsigned PRC_ST_BKERR = 3;
	localparam int unsigned PRC_ST_READY = 4;
	localparam int unsigned PRC_EV_W = 4;
	localparam int unsigned PRC_EV_START = 0;
	localparam int unsigned PRC_EV_STOP = 1;
	localparam int unsigned PRC_EV_BKERR = 2;
	localparam int unsigned PRC_EV_CLRDONE = 3;

	// Bus responses.
	localparam logic [1:0] PRC_RESP_OKAY = 2'h0;
	localparam logic [1:0] PRC_RESP_SLVERR = 2'h2;

	// Sequencer states, one-hot.
	typedef enum logic [3:0] {
		PRC_S_CFG = 4'h1,
		PRC_S_STOP = 4'h2,
		PRC_S_CLEAR = 4'h4,
		PRC_S_RUN = 4'h8
	} prc_state_t;

endpackage

// ---- rtl/prc_clear_walker.sv ----
/*
 One storage class clear walker: on a start pulse it steps once through every
 element index and strobes a clear for each index that its policy removes.
 Assumes the storage takes one clear strobe per clock without back-pressure.
*/
`timescale 1ns/10ps
module prc_clear_walker
	import prc_pkg::*;
#(
	parameter logic RANGE_KEEPS = 1'b1
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic [1:0] mode,
	input wire logic [9:0] lower,
	input wire logic [9:0] upper,
	output logic busy,
	output logic clr_valid,
	output logic [9:0] clr_index
);

	typedef struct packed {
		logic busy;
		logic [9:0] idx;
		logic [1:0] mode;
		logic [9:0] lo;
		logic [9:0] hi;
		logic vld;
		logic [9:0] oidx;
	} prc_walk_t;

	prc_walk_t q;
	prc_walk_t d;
	logic in_range;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// Settings are latched at start so a write during the walk cannot tear it.
	always_comb
	begin
		d = q;
		d.vld = 1'b0;
		in_range = (q.idx >= q.lo) && (q.idx <= q.hi);
		if (q.busy)
		begin
			d.oidx = q.idx;
			unique case (q.mode)
				PRC_MODE_CLEAR_ALL: d.vld = 1'b1;
				PRC_MODE_KEEP_ALL: d.vld = 1'b0;
				PRC_MODE_RANGE: d.vld = RANGE_KEEPS ? ~in_range : in_range;
				default: d.vld = 1'b0; // Undefined code keeps data, the safe side.
			endcase
			if (q.idx == PRC_IDX_LAST)
				d.busy = 1'b0;
			else
				d.idx = q.idx + 10'h001;
		end
		else if (start)
		begin
			d.busy = 1'b1;
			d.idx = 10'h000;
			d.mode = mode;
			d.lo = lower;
			d.hi = upper;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			q <= '0;
		else
			q <= d;
	end

	assign busy = q.busy;
	assign clr_valid = q.vld;
	assign clr_index = q.oidx;

endmodule // prc_clear_walker

// ---- rtl/prc_top.sv ----
/*
 Power-up run/stop sequencer with clear/keep control of four storage classes,
 reached over an AXI4-Lite slave, with a masked level interrupt.
 Assumes backup_error and retained_flag are valid from reset release, and that
 stop_in and reset_in are synchronous to clk.
// Operation
// - keep policy restores retained run/stop state
// - run policy sets flag and runs
// - stop policy clears flag, program halted
// - backup error uses backup policy instead
// - stop or reset input overrides policy
// - clearing happens only at operation start
// - relays clear-all, keep-all, keep-range; default clear
// - shift registers same three; default clear
// - counters keep, clear, clear-range; default keep
// - data registers same three; default keep
// - range set by lower and upper limit
// - special data registers always kept
// - special relays outside keep/clear control
// - resume only with flag set, inputs off
// - configurable run or stop on backup error
*/
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module prc_top
	import prc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic backup_error,
	input wire logic retained_flag,
	input wire logic stop_in,
	input wire logic reset_in,
	output logic start_control_flag,
	output logic program_run,
	output logic irq,
	output logic relay_clr_valid,
	output logic [9:0] relay_clr_index,
	output logic shift_clr_valid,
	output logic [9:0] shift_clr_index,
	output logic counter_clr_valid,
	output logic [9:0] counter_clr_index,
	output logic data_clr_valid,
	output logic [9:0] data_clr_index
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		prc_state_t st;
		logic flag;
		logic run;
		logic kick;
		logic bkerr;
		logic irq;
		logic [31:0] ctrl;
		logic [7:0] mode;
		logic [3:0][31:0] rng;
		logic [3:0] ists;
		logic [3:0] imask;
		logic awrdy;
		logic wrdy;
		logic bvalid;
		logic [1:0] bresp;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arrdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} prc_regs_t;

	localparam prc_regs_t PRC_REGS_RST = '{
		st: PRC_S_CFG,
		ctrl: PRC_CTRL_RST,
		mode: PRC_MODE_RST,
		awrdy: 1'b1,
		wrdy: 1'b1,
		arrdy: 1'b1,
		default: '0
	};

	prc_regs_t q;
	prc_regs_t d;
	logic [3:0] w_busy;
	logic [3:0] w_vld;
	logic [3:0][9:0] w_idx;
	logic any_busy;
	logic stop_hold;
	logic may_run;
	logic wr_hit;
	logic rd_hit;
	logic cmd_run;
	logic cmd_stop;
	logic [PRC_EV_W-1:0] ev;
	logic [PRC_EV_W-1:0] w1c;
	logic [31:0] rd_word;

	// Byte-lane merge of a write into a stored word.
	function automatic logic [31:0] prc_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

	// ------------------------------------------------------------------
	// Storage clear walkers
	// ------------------------------------------------------------------
	// only general storage has clear ports
	genvar g;
	generate
		for (g = 0; g < PRC_NCLS; g++)
		begin : g_walk
			prc_clear_walker #(
				.RANGE_KEEPS(PRC_RANGE_KEEPS[g])
			) u_walk (
				.clk(clk),
				.resetn(resetn),
				.start(q.kick),
				.mode(q.mode[2*g +: 2]),
				.lower(q.rng[g][PRC_RNG_LO_LSB +: PRC_IDX_W]),
				.upper(q.rng[g][PRC_RNG_HI_LSB +: PRC_IDX_W]),
				.busy(w_busy[g]),
				.clr_valid(w_vld[g]),
				.clr_index(w_idx[g])
			);
		end
	endgenerate

	assign any_busy = |w_busy;

	// ------------------------------------------------------------------
	// Next state: bus slave, registers, sequencer, interrupt
	// ------------------------------------------------------------------
	always_comb
	begin
		d = q;
		d.kick = 1'b0;
		ev = '0;
		w1c = '0;
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		cmd_run = 1'b0;
		cmd_stop = 1'b0;
		rd_word = 32'h00000000;

		stop_hold = (q.ctrl[PRC_CTRL_STOP_EN] & stop_in) | (q.ctrl[PRC_CTRL_RST_EN] & reset_in);
		may_run = q.flag & ~stop_hold;

		// Address and data are captured independently, in either order.
		if (s_axi_awvalid && q.awrdy)
		begin
			d.awrdy = 1'b0;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wrdy)
		begin
			d.wrdy = 1'b0;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end

		// Perform the write once both halves are held.
		if (!q.awrdy && !q.wrdy && !q.bvalid)
		begin
			wr_hit = 1'b1;
			unique case (q.awaddr)
				PRC_OFF_CTRL:
				begin
					d.ctrl = prc_merge(q.ctrl, q.wdata, q.wstrb) & PRC_CTRL_WMASK;
					cmd_run = q.wstrb[1] & q.wdata[PRC_CTRL_CMD_RUN];
					cmd_stop = q.wstrb[1] & q.wdata[PRC_CTRL_CMD_STOP];
				end
				PRC_OFF_STATUS: ; // Read-only; the write is accepted and dropped.
				PRC_OFF_INT_STATUS: w1c = q.wstrb[0] ? q.wdata[PRC_EV_W-1:0] : '0;
				PRC_OFF_INT_MASK:
				begin
					if (q.wstrb[0])
						d.imask = q.wdata[PRC_EV_W-1:0];
				end
				PRC_OFF_MODE:
				begin
					if (q.wstrb[0])
						d.mode = q.wdata[7:0];
				end
				default:
				begin
					wr_hit = 1'b0;
					for (int k = 0; k < PRC_NCLS; k++)
					begin
						if (q.awaddr == PRC_OFF_RANGE_BASE + 8'(4 * k))
						begin
							wr_hit = 1'b1;
							d.rng[k] = prc_merge(q.rng[k], q.wdata, q.wstrb) & PRC_RNG_WMASK;
						end
					end
				end
			endcase
			d.bvalid = 1'b1;
			d.bresp = wr_hit ? PRC_RESP_OKAY : PRC_RESP_SLVERR;
		end
		if (q.bvalid && s_axi_bready)
		begin
			d.bvalid = 1'b0;
			d.awrdy = 1'b1;
			d.wrdy = 1'b1;
		end

		// Read decode; unmapped addresses answer SLVERR with zero data.
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			PRC_OFF_CTRL: rd_word = q.ctrl;
			PRC_OFF_STATUS:
			begin
				rd_word[PRC_ST_FLAG] = q.flag;
				rd_word[PRC_ST_RUN] = q.run;
				rd_word[PRC_ST_CLEAR] = (q.st == PRC_S_CLEAR);
				rd_word[PRC_ST_BKERR] = q.bkerr;
				rd_word[PRC_ST_READY] = (q.st != PRC_S_CFG);
			end
			PRC_OFF_INT_STATUS: rd_word[PRC_EV_W-1:0] = q.ists;
			PRC_OFF_INT_MASK: rd_word[PRC_EV_W-1:0] = q.imask;
			PRC_OFF_MODE: rd_word[7:0] = q.mode;
			default:
			begin
				rd_hit = 1'b0;
				for (int k = 0; k < PRC_NCLS; k++)
				begin
					if (s_axi_araddr == PRC_OFF_RANGE_BASE + 8'(4 * k))
					begin
						rd_hit = 1'b1;
						rd_word = q.rng[k];
					end
				end
			end
		endcase
		if (s_axi_arvalid && q.arrdy)
		begin
			d.arrdy = 1'b0;
			d.rvalid = 1'b1;
			d.rdata = rd_word;
			d.rresp = rd_hit ? PRC_RESP_OKAY : PRC_RESP_SLVERR;
		end
		if (q.rvalid && s_axi_rready)
		begin
			d.rvalid = 1'b0;
			d.arrdy = 1'b1;
		end

		// Sequencer. The power-up choice waits for the go bit so that the
		// policies are in place before they are applied.
		unique case (q.st)
			PRC_S_CFG:
			begin
				if (q.ctrl[PRC_CTRL_GO])
				begin
					d.st = PRC_S_STOP;
					d.bkerr = backup_error;
					if (backup_error)
					begin
						d.flag = q.ctrl[PRC_CTRL_BKP_RUN];
						ev[PRC_EV_BKERR] = 1'b1;
					end
					else
					begin
						unique case (q.ctrl[PRC_CTRL_PUP_LSB +: 2])
							PRC_PUP_KEEP: d.flag = retained_flag;
							PRC_PUP_RUN: d.flag = 1'b1;
							PRC_PUP_STOP: d.flag = 1'b0;
							default: d.flag = 1'b0; // Undefined code stays stopped.
						endcase
					end
				end
			end
			PRC_S_STOP:
			begin
				if (may_run)
				begin
					d.st = PRC_S_CLEAR;
					d.kick = 1'b1;
				end
			end
			PRC_S_CLEAR:
			begin
				if (!q.kick && !any_busy)
				begin
					ev[PRC_EV_CLRDONE] = 1'b1;
					// A stop command landing now must not let one scan slip out without the flag.
					if (may_run && !cmd_stop)
					begin
						d.st = PRC_S_RUN;
						d.run = 1'b1;
						ev[PRC_EV_START] = 1'b1;
					end
					else
					begin
						d.st = PRC_S_STOP;
					end
				end
			end
			PRC_S_RUN:
			begin
				if (!may_run)
				begin
					d.st = PRC_S_STOP;
					d.run = 1'b0;
					ev[PRC_EV_STOP] = 1'b1;
				end
			end
			default:
			begin
				d.st = PRC_S_STOP;
				d.run = 1'b0;
			end
		endcase

		// Software run/stop commands, honoured once the power-up choice is made.
		if (q.st != PRC_S_CFG)
		begin
			if (cmd_stop)
				d.flag = 1'b0;
			else if (cmd_run)
				d.flag = 1'b1;
		end

		// A new event beats a clear written in the same cycle.
		d.ists = (q.ists & ~w1c) | ev;
		d.irq = |(d.ists & d.imask);
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			q <= PRC_REGS_RST;
		else
			q <= d;
	end

	// Outputs come straight from flops, here or inside the walkers.
	assign s_axi_awready = q.awrdy;
	assign s_axi_wready = q.wrdy;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arrdy;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rdata = q.rdata;
	assign start_control_flag = q.flag;
	assign program_run = q.run;
	assign irq = q.irq;

	assign relay_clr_valid = w_vld[0];
	assign relay_clr_index = w_idx[0];
	assign shift_clr_valid = w_vld[1];
	assign shift_clr_index = w_idx[1];
	assign counter_clr_valid = w_vld[2];
	assign counter_clr_index = w_idx[2];
	assign data_clr_valid = w_vld[3];
	assign data_clr_index = w_idx[3];

endmodule // prc_top

// ---- test/prc_switches.sv ----
/*
 Model of the far side: backup status, retained flag, stop and reset switches.
 Assumes the bench sets the wanted levels just after a rising edge.
*/
`timescale 1ns/10ps
module prc_switches
(
	input wire logic clk,
	input wire logic [3:0] want,
	output logic backup_error,
	output logic retained_flag,
	output logic stop_in,
	output logic reset_in
);
	// Levels settle one clock after they are thrown, like a debounced switch.
	always_ff @(posedge clk)
	begin
		{reset_in, stop_in, retained_flag, backup_error} <= want;
	end
endmodule // prc_switches

// ---- test/prc_top_asserts.sv ----
/*
 Checker for prc_top: bus holding, clear strobes and run gating.
 Assumes it is bound to prc_top and sees only its ports.
*/
`timescale 1ns/10ps
module prc_top_asserts
	import prc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic start_control_flag,
	input wire logic program_run,
	input wire logic relay_clr_valid,
	input wire logic [9:0] relay_clr_index,
	input wire logic data_clr_valid
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// Two relay strobes on back-to-back cycles.
	sequence relay_pair;
		relay_clr_valid ##1 relay_clr_valid;
	endsequence

	relay_no_run_a: assert property (relay_clr_valid |-> !program_run)
		else $error("relay strobe while running");
	data_no_run_a: assert property (data_clr_valid |-> !program_run)
		else $error("data strobe while running");
	relay_step_a: assert property (relay_pair |-> relay_clr_index == $past(relay_clr_index) + 10'h001)
		else $error("relay index skipped");
	run_flag_a: assert property ($rose(program_run) |-> start_control_flag)
		else $error("run rose without flag");
	flag_drop_a: assert property (!start_control_flag |=> !program_run)
		else $error("run kept without flag");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed");
	rd_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("read answer without request");
endmodule // prc_top_asserts

bind prc_top prc_top_asserts chk (.clk(clk), .resetn(resetn), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.start_control_flag(start_control_flag), .program_run(program_run),
	.relay_clr_valid(relay_clr_valid), .relay_clr_index(relay_clr_index), .data_clr_valid(data_clr_valid));

// ---- test/prc_top_bench.sv ----
/*
 Self-checking bench for prc_top: registers, power-up choices, clearing,
 stop and reset inputs, commands and the interrupt.
 Assumes prc_switches stands in for the switches and backup status.
*/
`timescale 1ns/10ps
module prc_top_bench;
	import prc_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [3:0] want = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, flag, run, irq, be, rf, si, ri;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [3:0] cv;
	logic [3:0][9:0] ix;
	logic [9:0] lix [4];
	int n_errors = 0;
	int cmp_count = 0;
	int cnt [4];
	// Columns: policy, backup run, backup error, retained flag, expected run.
	logic [5:0] tbl [7] = '{6'h03, 6'h00, 6'h11, 6'h22, 6'h16, 6'h2D, 6'h32};

	// ----------------------------------------
	// Clock, strobe counters, instances
	// ----------------------------------------
	always #20 clk = ~clk;

	// Counted at the falling edge so the tasks never race the counters.
	always @(negedge clk)
	begin
		for (int k = 0; k < 4; k++)
			if (cv[k] === 1'b1)
			begin
				cnt[k]++;
				lix[k] = ix[k];
			end
	end

	prc_switches u_sw (.clk(clk), .want(want), .backup_error(be), .retained_flag(rf), .stop_in(si), .reset_in(ri));

	prc_top DUT (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .backup_error(be),
		.retained_flag(rf), .stop_in(si), .reset_in(ri), .start_control_flag(flag), .program_run(run),
		.irq(irq), .relay_clr_valid(cv[0]), .relay_clr_index(ix[0]), .shift_clr_valid(cv[1]),
		.shift_clr_index(ix[1]), .counter_clr_valid(cv[2]), .counter_clr_index(ix[2]),
		.data_clr_valid(cv[3]), .data_clr_index(ix[3]));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task tmo(input logic out);
		if (out)
		begin
			n_errors++;
			$display("wait ran out at %0t", $time);
			summarize();
		end
	endtask

	// Ready outputs are taken before the edge lands, so each valid drops at its own handshake.
	task wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s);
		int n;
		logic pa, pw, fin;
		pa = 1'b1;
		pw = 1'b1;
		fin = 1'b0;
		n = 0;
		awaddr <= a;
		wdata <= dv;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b0;
		while (!fin && n < 100)
		begin
			@(posedge clk);
			n++;
			fin = bready === 1'b1 && bvalid === 1'b1;
			pa = pa && awready !== 1'b1;
			pw = pw && wready !== 1'b1;
			if (!fin)
			begin
				awvalid <= pa;
				wvalid <= pw;
				bready <= bvalid;
			end
		end
		r = bresp;
		tmo(n >= 100);
	endtask

	task rd(input logic [7:0] a);
		int n;
		logic pa, fin;
		pa = 1'b1;
		fin = 1'b0;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b0;
		while (!fin && n < 100)
		begin
			@(posedge clk);
			n++;
			fin = rready === 1'b1 && rvalid === 1'b1;
			pa = pa && arready !== 1'b1;
			if (!fin)
			begin
				arvalid <= pa;
				rready <= rvalid;
			end
		end
		d = rdata;
		r = rresp;
		tmo(n >= 100);
	endtask

	task wait_run(input logic e);
		int n;
		n = 0;
		while (run !== e && n < 1200)
		begin
			@(posedge clk);
			n++;
		end
		tmo(n >= 1200);
	endtask

	task do_reset(input logic [3:0] w);
		want <= w;
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		cnt = '{0, 0, 0, 0};
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs();
		rd(PRC_OFF_MODE);
		chk(d, {24'h0, PRC_MODE_RST});
		rd(8'h40);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, PRC_RESP_SLVERR});
		wr(8'h40, 32'h1, 4'hF);
		chk({30'h0, r}, {30'h0, PRC_RESP_SLVERR});
		$display("register test done");
	endtask

	task t_pups();
		logic [5:0] t;
		for (int i = 0; i < 7; i++)
		begin
			t = tbl[i];
			do_reset({2'b00, t[1], t[2]});
			wr(PRC_OFF_CTRL, {26'h0, 2'b00, t[3], t[5:4], 1'b1}, 4'hF);
			if (t[0])
				wait_run(1'b1);
			else
				repeat (1100) @(posedge clk);
			chk({30'h0, flag, run}, {30'h0, t[0], t[0]});
			rd(PRC_OFF_STATUS);
			chk({31'h0, d[PRC_ST_BKERR]}, {31'h0, t[2]});
		end
		$display("power-up test done");
	endtask

	task t_clear();
		do_reset(4'h0);
		chk({22'h0, lix[1]}, {22'h0, PRC_IDX_LAST});
		wr(PRC_OFF_MODE, 32'h26, 4'hF);
		wr(PRC_OFF_RANGE_BASE, 32'h000A0005, 4'hF);
		rd(PRC_OFF_RANGE_BASE);
		chk(d, 32'h000A0005);
		wr(PRC_OFF_RANGE_BASE + 8'h08, 32'h03FF03FF, 4'hF);
		wr(PRC_OFF_CTRL, 32'h3, 4'hF);
		wait_run(1'b1);
		chk(cnt[0], 1018);
		chk(cnt[1], 0);
		chk(cnt[2], 1);
		chk(cnt[3], 1024);
		chk({22'h0, lix[2]}, {22'h0, PRC_IDX_LAST});
		chk({22'h0, lix[3]}, {22'h0, PRC_IDX_LAST});
		chk({31'h0, irq}, 32'h0);
		rd(PRC_OFF_INT_STATUS);
		chk(d, 32'h9);
		wr(PRC_OFF_INT_MASK, 32'h1, 4'hF);
		@(posedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(PRC_OFF_INT_STATUS, 32'h1, 4'hF);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		$display("clearing test done");
	endtask

	task t_hold();
		wr(PRC_OFF_CTRL, 32'h33, 4'hF);
		for (int k = 2; k < 4; k++)
		begin
			want <= (k == 2) ? 4'h4 : 4'h8;
			wait_run(1'b0);
			cnt = '{0, 0, 0, 0};
			repeat (20) @(posedge clk);
			chk(cnt[0] + cnt[3], 0);
			want <= 4'h0;
			wait_run(1'b1);
			chk(cnt[3], 1024);
		end
		$display("hold test done");
	endtask

	task t_cmd();
		wr(PRC_OFF_CTRL, 32'h200, 4'h2);
		wait_run(1'b0);
		chk({31'h0, flag}, 32'h0);
		wr(PRC_OFF_MODE, 32'h3F, 4'h1);
		cnt = '{0, 0, 0, 0};
		wr(PRC_OFF_CTRL, 32'h100, 4'h2);
		wait_run(1'b1);
		chk({31'h0, flag}, 32'h1);
		chk(cnt[0] + cnt[1] + cnt[2], 0);
		chk(cnt[3], 1024);
		$display("command test done");
	endtask

	initial
	begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_pups();
		t_clear();
		t_hold();
		t_cmd();
		summarize();
	end
endmodule // prc_top_bench
